// ---- design/rpsc_map.vh ----
// How it works
// (R01) bit 0 reads live connect state
// (R02) bit 0 write one clears enable
// (R03) non-removable device: bit 0 reads one
// (R04) enable drops on faults, sets enable_change
// (R05) enable never set while disconnected
// (R06) reset/resume done with change sets enable
// (R07) set-enable write never sets enable
// (R08) set-enable while disconnected sets connect_change
// (R09) suspend set by command, cleared at resume end
// (R10) suspend clears on reset end, global resume
// (R11) suspend command while disconnected sets connect_change
// (R12) bit 3 follows overcurrent if per-port
// (R13) resume command acts only while suspended
// (R14) reset command drives reset, clears at done
// (R15) reset command while disconnected sets connect_change
// (R16) connect_change on every attach/detach while port power is on, w1c
// (R17) power off clears connect, enable, suspend, reset
// (R18) bits 7:5 reserved, read zero
// (R19) driver commands only connected ports
`ifndef RPSC_MAP_VH
`define RPSC_MAP_VH
// ----------------------------------------------------------
// register offsets
// ----------------------------------------------------------
`define RPSC_ADDR_PORT      12'h000
`define RPSC_ADDR_IRQ_STAT  12'h004
`define RPSC_ADDR_IRQ_MASK  12'h008
`define RPSC_ADDR_CTRL      12'h00c
// ----------------------------------------------------------
// port register bits
// ----------------------------------------------------------
`define RPSC_B_CONN         0
`define RPSC_B_EN           1
`define RPSC_B_SUSP         2
`define RPSC_B_OC           3
`define RPSC_B_RST          4
`define RPSC_B_PWR          8
`define RPSC_B_CONN_CHG     16
`define RPSC_B_EN_CHG       17
`define RPSC_B_SUSP_CHG     18
`define RPSC_B_RST_CHG      20
// ----------------------------------------------------------
// control register bits
// ----------------------------------------------------------
`define RPSC_B_PWR_SET      0
`define RPSC_B_PWR_CLR      1
// ----------------------------------------------------------
// timing: port reset 10 ms, resume 20 ms at 50 ns clock
// ----------------------------------------------------------
`define RPSC_CLK_NS         50
`define RPSC_RESET_US       10000
`define RPSC_RESUME_US      20000
`define RPSC_RESET_CYC      ((`RPSC_RESET_US * 1000) / `RPSC_CLK_NS)
`define RPSC_RESUME_CYC     ((`RPSC_RESUME_US * 1000) / `RPSC_CLK_NS)
`define RPSC_IRQ_W          4
`endif

// ---- design/rpsc_port.v ----
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rpsc_map.vh"
// ----------------------------------------------------------
// root port status and control, apb slave
// ----------------------------------------------------------
module rpsc_port #(
    parameter RESET_CYC  = `RPSC_RESET_CYC,   // port reset length
    parameter RESUME_CYC = `RPSC_RESUME_CYC,  // resume length
    parameter TW         = 20                 // timer width
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        dev_attached,      // pin, device present
    input  wire        dev_removable_n,   // pin, non-removable dev
    input  wire        overcurrent_in,    // pin, overcurrent
    input  wire        bus_error,         // babble etc, same clock
    input  wire        global_resume_state, // host_ctrl resume
    input  wire        per_port_oc,       // per-port oc strap
    output reg         port_reset_drive,  // reset signalling out
    output reg         port_resume_drive, // resume signalling out
    output wire        irq                // level interrupt
);
    // ------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------
    reg [1:0] att_s;                      // attach sync
    reg [1:0] nrm_s;                      // non-removable sync
    reg [1:0] oc_s;                       // overcurrent sync

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            att_s <= 2'b00;
            nrm_s <= 2'b00;
            oc_s  <= 2'b00;
        end else begin
            att_s <= {att_s[0], dev_attached};
            nrm_s <= {nrm_s[0], ~dev_removable_n};
            oc_s  <= {oc_s[0], overcurrent_in};
        end
    end

    // ------------------------------------------------------
    // state
    // ------------------------------------------------------
    reg connect_state;                    // live connect
    reg port_enabled;                     // enable flag
    reg port_suspended;                   // suspend flag
    reg port_reset_active;                // reset flag
    reg port_power_on;                    // power flag
    reg connect_change;                   // w1c
    reg enable_change;                    // w1c
    reg suspend_change;                   // w1c
    reg reset_change;                     // w1c
    reg [`RPSC_IRQ_W-1:0] irq_mask;       // interrupt mask
    wire port_oc;                         // visible overcurrent

    // ------------------------------------------------------
    // apb decode: zero wait, no errors
    // ------------------------------------------------------
    wire wr = psel & penable & pwrite;
    wire wr_port = wr & (paddr == `RPSC_ADDR_PORT);
    wire wr_stat = wr & (paddr == `RPSC_ADDR_IRQ_STAT);
    wire wr_mask = wr & (paddr == `RPSC_ADDR_IRQ_MASK);
    wire wr_ctrl = wr & (paddr == `RPSC_ADDR_CTRL);

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // command strobes from port and control register writes
    wire cmd_clr_en  = wr_port & pwdata[`RPSC_B_CONN];  // see (R02)
    wire cmd_set_en  = wr_port & pwdata[`RPSC_B_EN];
    wire cmd_susp    = wr_port & pwdata[`RPSC_B_SUSP];
    wire cmd_resume  = wr_port & pwdata[`RPSC_B_OC];
    wire cmd_reset   = wr_port & pwdata[`RPSC_B_RST];
    wire pwr_set     = wr_ctrl & pwdata[`RPSC_B_PWR_SET];
    wire pwr_clr     = wr_ctrl & pwdata[`RPSC_B_PWR_CLR];

    // w1c strobe for a change bit, from port or status reg
    function w1c;
        input integer pbit;
        input integer sbit;
        begin
            w1c = (wr_port & pwdata[pbit]) | (wr_stat & pwdata[sbit]);
        end
    endfunction

    // ------------------------------------------------------
    // timers for port reset and resume
    // ------------------------------------------------------
    wire rst_busy, rst_done, res_busy, res_done;
    wire start_rst = cmd_reset & connect_state & port_power_on
                     & ~port_reset_active;  // see (R14) (R15)
    wire start_res = cmd_resume & port_suspended & ~res_busy; // see (R13)
    wire drop      = ~att_s[1] | ~port_power_on; // link gone

    rpsc_timer #(.W(TW)) u_rst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (start_rst),
        .abort   (drop),
        .load    (RESET_CYC[TW-1:0]),
        .busy    (rst_busy),
        .done    (rst_done)
    );

    rpsc_timer #(.W(TW)) u_res (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (start_res),
        .abort   (drop | rst_done),
        .load    (RESUME_CYC[TW-1:0]),
        .busy    (res_busy),
        .done    (res_done)
    );

    // ------------------------------------------------------
    // connect, power and change events
    // ------------------------------------------------------
    wire next_conn   = att_s[1] & port_power_on;     // see (R17)
    wire conn_edge   = next_conn ^ connect_state;    // see (R16)
    wire bad_cmd     = ~connect_state &
                       (cmd_set_en | cmd_susp | cmd_reset); // see (R08) (R11) (R15)
    // enable drops on oc, disconnect, power loss, bus error
    wire en_fault    = port_enabled &
                       (oc_s[1] | ~next_conn | bus_error); // see (R04)
    wire en_hw_set   = (rst_done | res_done) & next_conn;  // see (R06) (R05)

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_power_on <= 1'b0;
            connect_state <= 1'b0;
        end else begin
            if (pwr_set) begin
                port_power_on <= 1'b1;
            end else if (pwr_clr | oc_s[1]) begin
                port_power_on <= 1'b0;
            end
            connect_state <= next_conn;               // see (R01)
        end
    end

    // ------------------------------------------------------
    // enable, suspend, reset flags
    // ------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_enabled      <= 1'b0;
            port_suspended    <= 1'b0;
            port_reset_active <= 1'b0;
        end else begin
            // set-enable command ignored by design, see (R07)
            if (en_fault | cmd_clr_en) begin
                port_enabled <= 1'b0;
            end else if (en_hw_set) begin
                port_enabled <= 1'b1;                 // see (R06)
            end
            // suspend flag
            if (~next_conn | rst_done | global_resume_state
                | res_done) begin
                port_suspended <= 1'b0;               // see (R09) (R10)
            end else if (cmd_susp & connect_state) begin
                port_suspended <= 1'b1;               // see (R09) (R11)
            end
            // reset flag
            if (~next_conn | rst_done) begin
                port_reset_active <= 1'b0;            // see (R14) (R17)
            end else if (start_rst) begin
                port_reset_active <= 1'b1;            // see (R14)
            end
        end
    end

    // ------------------------------------------------------
    // change flags, set wins over clear
    // ------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            connect_change <= 1'b0;
            enable_change  <= 1'b0;
            suspend_change <= 1'b0;
            reset_change   <= 1'b0;
        end else begin
            if (conn_edge | bad_cmd) begin
                connect_change <= 1'b1;               // see (R16) (R08)
            end else if (w1c(`RPSC_B_CONN_CHG, 0)) begin
                connect_change <= 1'b0;
            end
            if (en_fault) begin
                enable_change <= 1'b1;                // see (R04)
            end else if (w1c(`RPSC_B_EN_CHG, 1)) begin
                enable_change <= 1'b0;
            end
            if (res_done) begin
                suspend_change <= 1'b1;               // see (R09)
            end else if (w1c(`RPSC_B_SUSP_CHG, 2)) begin
                suspend_change <= 1'b0;
            end
            if (rst_done) begin
                reset_change <= 1'b1;                 // see (R14)
            end else if (w1c(`RPSC_B_RST_CHG, 3)) begin
                reset_change <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------
    // port signalling outputs and mask
    // ------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_reset_drive  <= 1'b0;
            port_resume_drive <= 1'b0;
            irq_mask          <= {`RPSC_IRQ_W{1'b0}};
        end else begin
            port_reset_drive  <= rst_busy | start_rst;  // see (R14)
            port_resume_drive <= res_busy | start_res;  // see (R13)
            if (wr_mask) begin
                irq_mask <= pwdata[`RPSC_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------
    // interrupt and read data
    // ------------------------------------------------------
    wire [`RPSC_IRQ_W-1:0] irq_stat = {reset_change, suspend_change,
                                       enable_change, connect_change};
    assign irq     = |(irq_stat & irq_mask);
    assign port_oc = per_port_oc & oc_s[1];            // see (R12)

    reg [31:0] next_rdata;                             // read mux

    always @* begin
        next_rdata = 32'h0000_0000;                    // see (R18)
        case (paddr)
            `RPSC_ADDR_PORT: begin
                next_rdata[`RPSC_B_CONN]     = connect_state
                                               | nrm_s[1]; // see (R01) (R03)
                next_rdata[`RPSC_B_EN]       = port_enabled;
                next_rdata[`RPSC_B_SUSP]     = port_suspended;
                next_rdata[`RPSC_B_OC]       = port_oc;
                next_rdata[`RPSC_B_RST]      = port_reset_active;
                next_rdata[`RPSC_B_PWR]      = port_power_on;
                next_rdata[`RPSC_B_CONN_CHG] = connect_change;
                next_rdata[`RPSC_B_EN_CHG]   = enable_change;
                next_rdata[`RPSC_B_SUSP_CHG] = suspend_change;
                next_rdata[`RPSC_B_RST_CHG]  = reset_change;
            end
            `RPSC_ADDR_IRQ_STAT: begin
                next_rdata[`RPSC_IRQ_W-1:0] = irq_stat;
            end
            `RPSC_ADDR_IRQ_MASK: begin
                next_rdata[`RPSC_IRQ_W-1:0] = irq_mask;
            end
            `RPSC_ADDR_CTRL: begin
                next_rdata[`RPSC_B_PWR_SET] = port_power_on;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // register read data in setup phase
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_rdata;
        end
    end
endmodule // rpsc_port
`default_nettype wire

// ---- design/rpsc_timer.v ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// one-shot down counter, pulses done at expiry
// ----------------------------------------------------------
module rpsc_timer #(
    parameter W = 20
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire         start,    // load pulse
    input  wire         abort,    // cancel run
    input  wire [W-1:0] load,     // cycles to run
    output reg          busy,     // running
    output reg          done      // one-cycle expiry
);
    reg [W-1:0] cnt;              // remaining cycles

    // count down while busy
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt  <= {W{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                cnt  <= load;
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // rpsc_timer
`default_nettype wire

// ---- dv/root_port_status_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rpsc_map.vh"
// ----------------------------------------------------------
// port register bench
// ----------------------------------------------------------
module root_port_status_control_tb;
    logic        clk = 0, sys_rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, seed = 32'h099ff5a8;
    logic        glob = 0, ppoc = 0, att = 0, fix = 0, oc = 0, bab = 0;
    wire         pready, pslverr, irq, rst_drv, res_drv;
    wire         d_att, d_rem_n, d_oc, berr;
    wire  [31:0] prdata;
    int          n_fail = 0, compares = 0, i;

    always #25 clk = ~clk;             // 20 MHz

    rpsc_port #(.RESET_CYC(8), .RESUME_CYC(12)) u_dut (.clk, .sys_rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .dev_attached(d_att), .dev_removable_n(d_rem_n),
        .overcurrent_in(d_oc), .bus_error(berr), .global_resume_state(glob),
        .per_port_oc(ppoc), .port_reset_drive(rst_drv),
        .port_resume_drive(res_drv), .irq);
    rpsc_dev u_devm (.clk, .attach_req(att), .fixed_req(fix), .oc_req(oc),
        .babble_req(bab), .dev_attached(d_att), .dev_removable_n(d_rem_n),
        .overcurrent_in(d_oc), .bus_error(berr));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic [31:0] xs(input [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, entered just after an edge
    task apb(input [11:0] a, input w, input [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task rdp(input [31:0] m, input [31:0] e, input string nm);
        apb(`RPSC_ADDR_PORT, 1'b0, 32'h0);
        check(nm, rd & m, e);
    endtask
    // bounded wait for reset or resume signalling to end
    task wait_idle;
        int k;
        for (k = 0; k < 100 && (rst_drv || res_drv); k++) @(posedge clk);
        check("drive idle", {30'h0, rst_drv, res_drv}, 32'h0);
    endtask
    task wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin                      // watchdog, 20000 cycles
        #1000000;
        n_fail++;
        wrap_up;
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        rdp(32'hffffffff, 32'h0, "port idle");
        for (i = 1; i < 5; i++) begin  // commands to an empty port
            if (i == 3) continue;
            wr(`RPSC_ADDR_PORT, 32'h1 << i);
            rdp(32'h0001001f, 32'h00010000, "cmd empty");
            wr(`RPSC_ADDR_PORT, 32'h00010000);
            rdp(32'h00010000, 32'h0, "change w1c");
        end
        wr(`RPSC_ADDR_CTRL, 32'h1);
        att <= 1;
        repeat (6) @(posedge clk);
        rdp(32'h00010003, 32'h00010001, "attach");
        wr(`RPSC_ADDR_PORT, 32'h00010002);
        rdp(32'h2, 32'h0, "set enable");
        wr(`RPSC_ADDR_PORT, 32'h10);
        rdp(32'h10, 32'h10, "reset active");
        wait_idle;
        rdp(32'h00100016, 32'h00100002, "reset done");
        wr(`RPSC_ADDR_PORT, 32'h4);
        rdp(32'h4, 32'h4, "suspend");
        wr(`RPSC_ADDR_PORT, 32'h8);
        wait_idle;
        rdp(32'h00040006, 32'h00040002, "resume done");
        wr(`RPSC_ADDR_PORT, 32'h8);
        repeat (3) @(posedge clk);
        check("idle resume", {31'h0, res_drv}, 32'h0);
        wr(`RPSC_ADDR_PORT, 32'h4);
        glob <= 1;
        repeat (2) @(posedge clk);
        glob <= 0;
        rdp(32'h4, 32'h0, "global resume");
        wr(`RPSC_ADDR_PORT, 32'h1);
        rdp(32'h3, 32'h1, "clear enable");
        wr(`RPSC_ADDR_PORT, 32'h10);
        wait_idle;
        wr(`RPSC_ADDR_PORT, 32'h00170000);
        bab <= 1;
        repeat (3) @(posedge clk);
        bab <= 0;
        rdp(32'h00020002, 32'h00020000, "babble");
        wr(`RPSC_ADDR_IRQ_MASK, 32'h2);
        @(negedge clk) check("irq on", {31'h0, irq}, 32'h1);
        wr(`RPSC_ADDR_IRQ_MASK, 32'h0);
        @(negedge clk) check("irq masked", {31'h0, irq}, 32'h0);
        wr(`RPSC_ADDR_IRQ_MASK, 32'h2);
        wr(`RPSC_ADDR_IRQ_STAT, 32'h2);
        @(negedge clk) check("irq cleared", {31'h0, irq}, 32'h0);
        wr(`RPSC_ADDR_PORT, 32'h10);
        wait_idle;
        wr(`RPSC_ADDR_CTRL, 32'h2);
        rdp(32'h17, 32'h0, "power off");
        ppoc <= 1;
        oc <= 1;
        repeat (6) @(posedge clk);
        rdp(32'h8, 32'h8, "overcurrent");
        ppoc <= 0;
        repeat (6) @(posedge clk);
        rdp(32'h8, 32'h0, "oc unsupported");
        oc <= 0;
        fix <= 1;
        repeat (6) @(posedge clk);
        rdp(32'h1, 32'h1, "fixed device");
        for (i = 0; i < 8; i++) begin  // random reserved and unmapped
            seed = xs(seed);
            wr(`RPSC_ADDR_PORT, seed & 32'h000000e0);
            rdp(32'he0, 32'h0, "reserved");
            // offset kept above the map so it never wraps onto a register
            apb(12'h010 + {2'b00, seed[7:0], 2'b00}, 1'b0, 32'h0);
            check("unmapped", rd, 32'h0);
        end
        wrap_up;
    end
endmodule // root_port_status_control_tb
bind rpsc_port rpsc_port_properties #(.RESET_CYC(RESET_CYC)) u_chk (.clk,
    .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .dev_attached, .dev_removable_n, .overcurrent_in, .bus_error,
    .global_resume_state, .per_port_oc, .port_reset_drive,
    .port_resume_drive, .irq);
`default_nettype wire

// ---- dv/rpsc_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// downstream device model on the port pins
// ----------------------------------------------------------
module rpsc_dev (
    input  wire logic clk,
    input  wire logic attach_req,      // bench: plug device in
    input  wire logic fixed_req,       // bench: device soldered down
    input  wire logic oc_req,          // bench: load draws too much
    input  wire logic babble_req,      // bench: device babbles
    output var  logic dev_attached,
    output var  logic dev_removable_n,
    output var  logic overcurrent_in,
    output var  logic bus_error
);
    logic bab_q = 1'b0;                // edge finder for babble

    // pins follow the bench requests as levels
    always_comb begin
        dev_attached    = attach_req;
        dev_removable_n = !fixed_req;
        overcurrent_in  = oc_req;
    end

    // babble is one pulse, only from a device on the wire
    always_ff @(posedge clk) begin
        bab_q     <= babble_req;
        bus_error <= babble_req && !bab_q && attach_req;
    end
endmodule // rpsc_dev
`default_nettype wire

// ---- dv/rpsc_port_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rpsc_map.vh"
// ----------------------------------------------------------
// port register checker
// ----------------------------------------------------------
module rpsc_port_properties #(
    parameter RESET_CYC = 8
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        dev_attached,
    input wire logic        dev_removable_n,
    input wire logic        overcurrent_in,
    input wire logic        bus_error,
    input wire logic        global_resume_state,
    input wire logic        per_port_oc,
    input wire logic        port_reset_drive,
    input wire logic        port_resume_drive,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire rd_acc = psel && penable && !pwrite;         // read access
    wire rd_port = rd_acc && paddr == `RPSC_ADDR_PORT;
    wire wr_port = psel && penable && pwrite && paddr == `RPSC_ADDR_PORT;
    logic [1:0] oc_q;                                  // last oc inputs
    logic       fix_q;                                 // last fixed pin
    logic [2:0] oc_age, fix_age;                       // stable edges
    logic [7:0] rst_len;                               // reset drive run

    // input age and reset drive length
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_q    <= 2'b00;
            fix_q   <= 1'b1;
            oc_age  <= 3'd0;
            fix_age <= 3'd0;
            rst_len <= 8'd0;
        end else begin
            oc_q    <= {per_port_oc, overcurrent_in};
            fix_q   <= dev_removable_n;
            oc_age  <= (oc_q != {per_port_oc, overcurrent_in}) ? 3'd0 :
                       (oc_age == 3'd7 ? oc_age : oc_age + 3'd1);
            fix_age <= (fix_q != dev_removable_n) ? 3'd0 :
                       (fix_age == 3'd7 ? fix_age : fix_age + 3'd1);
            rst_len <= port_reset_drive ? rst_len + 8'd1 : 8'd0;
        end
    end

    en_needs_conn_a: assert property (rd_port |-> !prdata[1] || prdata[0])
        else $error("enabled read while disconnected");
    reserved_zero_a: assert property (rd_port |-> prdata[7:5] == 3'h0)
        else $error("reserved bits not zero");
    oc_follow_a: assert property (rd_port && oc_age == 3'd7
        |-> prdata[3] == (per_port_oc && overcurrent_in))
        else $error("overcurrent bit wrong");
    fixed_one_a: assert property (rd_port && fix_age == 3'd7
        && !dev_removable_n |-> prdata[0])
        else $error("fixed device bit0 not one");
    reset_cause_a: assert property ($rose(port_reset_drive)
        |-> $past(wr_port && pwdata[4]) || $past(wr_port && pwdata[4], 2))
        else $error("reset drive without command");
    reset_len_a: assert property ($fell(port_reset_drive)
        |-> rst_len >= RESET_CYC - 1 && rst_len <= RESET_CYC + 1)
        else $error("reset drive length wrong");
    resume_cause_a: assert property ($rose(port_resume_drive)
        |-> $past(wr_port && pwdata[3]) || $past(wr_port && pwdata[3], 2))
        else $error("resume drive without command");
    unmapped_zero_a: assert property (rd_acc && paddr > `RPSC_ADDR_CTRL
        |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    ready_ok_a: assert property (psel && penable |-> pready && !pslverr)
        else $error("apb answer wrong");

    cover property ($fell(port_reset_drive));
    cover property ($fell(port_resume_drive));
    cover property ($rose(irq));
endmodule // rpsc_port_properties
`default_nettype wire
